// *** hdl/lsu_params.svh ***
// constants for the immediate-offset address generator and load/store sequencer
`ifndef LSU_PARAMS_SVH
`define LSU_PARAMS_SVH

`define IMM_LIMIT_PLAIN  12'hFFF
`define IMM_LIMIT_INDEX  12'h0FF
`define IMM_LIMIT_PAIR   12'h3FC
`define PAIR_STEP        32'h0000_0004
`define PC_INDEX         4'hF
`define ZERO_WORD        32'h0000_0000

`endif

// *** hdl/lsu_pkg.sv ***
// types shared by the load/store sequencer and its load extender
`default_nettype none
package lsu_pkg;
    typedef enum logic [1:0] {OP_ADR = 2'h0, OP_LOAD = 2'h1, OP_STORE = 2'h2} op_kind_t;
    typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2,
                              SZ_PAIR = 2'h3} size_t;
    typedef enum logic [1:0] {AM_OFFSET = 2'h0, AM_PRE = 2'h1, AM_POST = 2'h2} addr_mode_t;
    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_FIRST = 3'b010,
                              ST_SECOND = 3'b100} fsm_t;

    // one decoded instruction with its operand values
    typedef struct packed {
        op_kind_t   kind;
        size_t      size;
        logic       sign_ext;
        addr_mode_t mode;
        logic       cond_pass;
        logic       add_offset;
        logic [11:0] imm;
        logic [3:0] transfer_register;
        logic [3:0] second_transfer_register;
        logic [3:0] base_register;
        logic [31:0] base_val;
        logic [31:0] pc_val;
        logic [31:0] store_data;
        logic [31:0] store_data2;
    } instr_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        size_t       size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic        en;
        logic [3:0]  idx;
        logic [31:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic        en;
        logic [31:0] target;
    } branch_t;

    typedef struct packed {
        fsm_t        fsm;
        logic        ready;
        instr_t      ins;
        logic [31:0] addr;
        logic [31:0] wb_addr;
        mem_req_t    mem;
        reg_wr_t     tr_wr;
        reg_wr_t     base_wr;
        branch_t     branch;
        logic        done;
        logic        fault;
    } state_t;
endpackage
`default_nettype wire

// *** hdl/load_extend.sv ***
// widens a right-justified load value to a full word
`default_nettype none
module load_extend
    import lsu_pkg::*;
(
    input  wire size_t       size,     // transfer size
    input  wire logic        sign_ext, // sign rather than zero fill
    input  wire logic [31:0] raw,      // memory data, low lanes valid
    output logic      [31:0] ext       // widened value
);
    // -----------------------------------------------------------------
    // extension
    // -----------------------------------------------------------------
    // memory returns narrow data in the low lanes, so only the fill differs
    always_comb begin
        unique case (size)
            SZ_BYTE: ext = {{24{sign_ext & raw[7]}}, raw[7:0]};
            SZ_HALF: ext = {{16{sign_ext & raw[15]}}, raw[15:0]};
            default: ext = raw;
        endcase
    end
endmodule
`default_nettype wire

// *** hdl/lsu_seq.sv ***
// immediate-offset address generation and load/store sequencing
`include "lsu_params.svh"
`default_nettype none
module lsu_seq
    import lsu_pkg::*;
(
    input  wire logic        sys_clk,     // core clock
    input  wire logic        rst,         // synchronous reset, high
    input  wire logic        instr_valid, // decoded instruction offered
    input  wire instr_t      instr,       // decoded instruction
    output logic             instr_ready, // sequencer can take one
    output mem_req_t         mem_req,     // one-cycle memory request
    input  wire logic        mem_rvalid,  // memory answer for last request
    input  wire logic [31:0] mem_rdata,   // load data, right-justified
    output reg_wr_t          tr_wr,       // transfer register write
    output reg_wr_t          base_wr,     // base writeback
    output branch_t          branch,      // program counter redirect
    output logic             done,        // instruction retired
    output logic             fault,       // offset outside its range, or unaligned pair offset
    output logic             flags_we     // condition flag write, never set
);
    state_t      s_reg;
    state_t      s_next;
    state_t      rst_val;
    logic [31:0] ext_data;
    logic [31:0] calc_addr;
    logic [31:0] adr_sum;
    logic [11:0] imm_limit;
    logic        range_bad;
    logic        take;

    load_extend u_ext (
        .size     (s_reg.ins.size),
        .sign_ext (s_reg.ins.sign_ext),
        .raw      (mem_rdata),
        .ext      (ext_data)
    );

    // -----------------------------------------------------------------
    // address arithmetic
    // -----------------------------------------------------------------
    // both sums come straight from the offered instruction
    always_comb begin
        calc_addr = instr.add_offset ? instr.base_val + {20'h0, instr.imm}
                                     : instr.base_val - {20'h0, instr.imm};
        adr_sum   = instr.add_offset ? instr.pc_val + {20'h0, instr.imm}
                                     : instr.pc_val - {20'h0, instr.imm};
        take      = instr_valid & s_reg.ready;
    end

    // legal offset bounds differ by size, mode and direction
    always_comb begin
        if (instr.size == SZ_PAIR)
            imm_limit = `IMM_LIMIT_PAIR;
        else if (instr.mode == AM_OFFSET && instr.add_offset)
            imm_limit = `IMM_LIMIT_PLAIN;
        else
            imm_limit = `IMM_LIMIT_INDEX;
        range_bad = (instr.imm > imm_limit) |
                    ((instr.size == SZ_PAIR) & (instr.imm[1:0] != 2'h0));
    end

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    // output pulses clear every cycle; only the state fields persist
    always_comb begin
        s_next              = s_reg;
        s_next.mem.valid    = 1'b0;
        s_next.tr_wr.en     = 1'b0;
        s_next.base_wr.en   = 1'b0;
        s_next.branch.en    = 1'b0;
        s_next.done         = 1'b0;
        s_next.fault        = 1'b0;
        unique case (s_reg.fsm)
            ST_IDLE: begin
                if (take) begin
                    s_next.ins = instr;
                    if (!instr.cond_pass) begin
                        s_next.done = 1'b1;
                    end else if (instr.kind == OP_ADR) begin
                        s_next.tr_wr.en   = 1'b1;
                        s_next.tr_wr.idx  = instr.transfer_register;
                        s_next.tr_wr.data = adr_sum;
                        s_next.done       = 1'b1;
                    end else if (range_bad) begin
                        // a refused offset leaves memory and registers untouched
                        s_next.fault = 1'b1;
                        s_next.done  = 1'b1;
                    end else begin
                        s_next.addr      = (instr.mode == AM_POST) ? instr.base_val
                                                                   : calc_addr;
                        s_next.wb_addr   = calc_addr;
                        s_next.mem.valid = 1'b1;
                        s_next.mem.write = (instr.kind == OP_STORE);
                        s_next.mem.size  = (instr.size == SZ_PAIR) ? SZ_WORD : instr.size;
                        s_next.mem.addr  = (instr.mode == AM_POST) ? instr.base_val
                                                                   : calc_addr;
                        // narrow stores carry only their low lanes
                        unique case (instr.size)
                            SZ_BYTE: s_next.mem.wdata = {24'h0, instr.store_data[7:0]};
                            SZ_HALF: s_next.mem.wdata = {16'h0, instr.store_data[15:0]};
                            default: s_next.mem.wdata = instr.store_data;
                        endcase
                        s_next.ready = 1'b0;
                        s_next.fsm   = ST_FIRST;
                    end
                end
            end
            ST_FIRST: begin
                if (mem_rvalid) begin
                    if (s_reg.ins.kind == OP_LOAD) begin
                        // word load into pc redirects rather than writing the file
                        if (s_reg.ins.transfer_register == `PC_INDEX &&
                            s_reg.ins.size == SZ_WORD) begin
                            s_next.branch.en     = 1'b1;
                            s_next.branch.target = {mem_rdata[31:1], 1'b0};
                        end else begin
                            s_next.tr_wr.en   = 1'b1;
                            s_next.tr_wr.idx  = s_reg.ins.transfer_register;
                            s_next.tr_wr.data = ext_data;
                        end
                    end
                    if (s_reg.ins.size == SZ_PAIR) begin
                        s_next.mem.valid = 1'b1;
                        s_next.mem.addr  = s_reg.addr + `PAIR_STEP;
                        s_next.mem.wdata = s_reg.ins.store_data2;
                        s_next.fsm       = ST_SECOND;
                    end else begin
                        s_next.base_wr.en   = (s_reg.ins.mode != AM_OFFSET);
                        s_next.base_wr.idx  = s_reg.ins.base_register;
                        s_next.base_wr.data = s_reg.wb_addr;
                        s_next.done         = 1'b1;
                        s_next.ready        = 1'b1;
                        s_next.fsm          = ST_IDLE;
                    end
                end
            end
            ST_SECOND: begin
                if (mem_rvalid) begin
                    // pair targets are distinct, so both writes are safe in order
                    if (s_reg.ins.kind == OP_LOAD) begin
                        s_next.tr_wr.en   = 1'b1;
                        s_next.tr_wr.idx  = s_reg.ins.second_transfer_register;
                        s_next.tr_wr.data = mem_rdata;
                    end
                    s_next.base_wr.en   = (s_reg.ins.mode != AM_OFFSET);
                    s_next.base_wr.idx  = s_reg.ins.base_register;
                    s_next.base_wr.data = s_reg.wb_addr;
                    s_next.done         = 1'b1;
                    s_next.ready        = 1'b1;
                    s_next.fsm          = ST_IDLE;
                end
            end
        endcase
    end

    // reset image: idle and ready, every pulse and data field cleared
    always_comb begin
        rst_val       = '0;
        rst_val.fsm   = ST_IDLE;
        rst_val.ready = 1'b1;
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_reg <= rst_val;
        end else begin
            s_reg <= s_next;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    always_comb begin
        instr_ready = s_reg.ready;
        mem_req     = s_reg.mem;
        tr_wr       = s_reg.tr_wr;
        base_wr     = s_reg.base_wr;
        branch      = s_reg.branch;
        done        = s_reg.done;
        fault       = s_reg.fault;
        flags_we    = 1'b0;
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_adr_sum;
        take && instr.cond_pass && instr.kind == OP_ADR |=>
            tr_wr.en && done && !fault && tr_wr.data == $past(adr_sum);
    endproperty
    a_adr_sum: assert property (p_adr_sum) else $error("address generation sum wrong");

    property p_adr_range;
        take && instr.cond_pass && instr.kind == OP_ADR && instr.imm == 12'hFFF |=> !fault;
    endproperty
    a_adr_range: assert property (p_adr_range) else $error("full adr distance refused");

    property p_no_flags;
        done |-> !flags_we;
    endproperty
    a_no_flags: assert property (p_no_flags) else $error("flags written");

    property p_offset_addr;
        take && instr.cond_pass && instr.kind != OP_ADR && !range_bad &&
            instr.mode != AM_POST |=> mem_req.valid && mem_req.addr == $past(calc_addr);
    endproperty
    a_offset_addr: assert property (p_offset_addr) else $error("access address wrong");

    property p_post_addr;
        take && instr.cond_pass && instr.kind != OP_ADR && !range_bad &&
            instr.mode == AM_POST |=> mem_req.valid && mem_req.addr == $past(instr.base_val);
    endproperty
    a_post_addr: assert property (p_post_addr) else $error("post-index address wrong");

    property p_offset_no_wb;
        done && s_reg.ins.mode == AM_OFFSET |-> !base_wr.en;
    endproperty
    a_offset_no_wb: assert property (p_offset_no_wb) else $error("offset form wrote base");

    property p_pre_wb;
        done && base_wr.en && s_reg.ins.mode == AM_PRE && s_reg.ins.size != SZ_PAIR |->
            base_wr.data == s_reg.addr;
    endproperty
    a_pre_wb: assert property (p_pre_wb) else $error("pre-index writeback wrong");

    property p_index_range;
        take && instr.cond_pass && instr.kind == OP_LOAD && instr.mode == AM_PRE &&
            instr.size == SZ_WORD && instr.imm > 12'h0FF |=> fault && !mem_req.valid;
    endproperty
    a_index_range: assert property (p_index_range) else $error("indexed range not refused");

    property p_pair_align;
        take && instr.cond_pass && instr.kind != OP_ADR && instr.size == SZ_PAIR &&
            instr.imm[1:0] != 2'h0 |=> fault && !mem_req.valid;
    endproperty
    a_pair_align: assert property (p_pair_align) else $error("unaligned pair offset taken");

    property p_pair_step;
        mem_req.valid && s_reg.fsm == ST_SECOND |-> mem_req.addr == s_reg.addr + `PAIR_STEP;
    endproperty
    a_pair_step: assert property (p_pair_step) else $error("second word address wrong");

    property p_pc_branch;
        branch.en |-> branch.target == {$past(mem_rdata) & 32'hFFFF_FFFE} && !tr_wr.en;
    endproperty
    a_pc_branch: assert property (p_pc_branch) else $error("pc load branch wrong");

    property p_cond_fail;
        take && !instr.cond_pass |=> done && !mem_req.valid && !tr_wr.en && !base_wr.en;
    endproperty
    a_cond_fail: assert property (p_cond_fail) else $error("failed condition had effect");

    property p_zero_ext;
        s_reg.fsm == ST_FIRST && mem_rvalid && s_reg.ins.kind == OP_LOAD &&
            s_reg.ins.size == SZ_BYTE && !s_reg.ins.sign_ext |=> tr_wr.data[31:8] == 24'h0;
    endproperty
    a_zero_ext: assert property (p_zero_ext) else $error("byte load not zero filled");

    c_pair_load: cover property (s_reg.fsm == ST_SECOND && mem_rvalid &&
                                 s_reg.ins.kind == OP_LOAD);
    c_pc_branch: cover property (branch.en);
    c_post_store: cover property (base_wr.en && s_reg.ins.mode == AM_POST &&
                                  s_reg.ins.kind == OP_STORE);
endmodule
`default_nettype wire

// *** test/mem_model.sv ***
// memory partner model answering load and store requests after a set latency
`default_nettype none
module mem_model
    import lsu_pkg::*;
(
    input  wire logic        sys_clk,    // core clock
    input  wire logic        rst,        // synchronous reset, high
    input  wire mem_req_t    mem_req,    // request from the sequencer
    input  wire logic [3:0]  lat,        // answer latency in cycles, at least 1
    output logic             mem_rvalid, // one-cycle answer
    output logic      [31:0] mem_rdata   // load data, upper lanes left dirty
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0]  cnt_reg;
    logic [31:0] addr_reg;

    // ----------------------------------------
    // answer path
    // ----------------------------------------
    // data lines toggle when idle, so a stale word never looks like an answer
    always_ff @(posedge sys_clk) begin
        mem_rvalid <= 1'b0;
        mem_rdata  <= ~mem_rdata;
        if (rst) begin
            cnt_reg   <= 4'h0;
            mem_rdata <= 32'h5A5A_5A5A;
        end else if (mem_req.valid) begin
            cnt_reg  <= lat;
            addr_reg <= mem_req.addr;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h1) begin
                mem_rvalid <= 1'b1;
                // whole word returned: the sequencer must extend from the low lanes
                mem_rdata  <= {addr_reg[15:0] ^ 16'h8F3C, addr_reg[15:0] ^ 16'h3CA5};
            end
        end
    end
endmodule
`default_nettype wire

// *** test/load_store_imm_address_gen_bench.sv ***
// bench for the immediate-offset load/store sequencer with its memory partner
`default_nettype none
module load_store_imm_address_gen_bench
    import lsu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        instr_valid = 1'b0;
    instr_t      instr = '0;
    logic [3:0]  lat = 4'h1;
    logic        instr_ready, mem_rvalid, done, fault, flags_we;
    logic [31:0] mem_rdata;
    mem_req_t    mem_req;
    reg_wr_t     tr_wr, base_wr;
    branch_t     branch;
    int          error_cnt = 0;
    int          checked = 0;
    // what one instruction produced at the ports
    logic [31:0] req_addr[4], req_wdata[4], tr_data[4];
    logic [3:0]  tr_idx[4], base_idx;
    logic        req_wr[4];
    size_t       req_size[4];
    int          n_req, n_tr, n_base, n_br;
    logic [31:0] base_data, br_tgt;
    logic        flt;

    always #12.5 sys_clk = ~sys_clk;

    lsu_seq i_lsu_seq (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .mem_req(mem_req),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .tr_wr(tr_wr),
        .base_wr(base_wr), .branch(branch), .done(done), .fault(fault),
        .flags_we(flags_we));
    mem_model i_mem_model (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .lat(lat),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // word the memory partner returns for an address
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[15:0] ^ 16'h8F3C, a[15:0] ^ 16'h3CA5};
    endfunction

    // base kept apart from both targets, no store from or based on reg 15
    function automatic instr_t mk(op_kind_t k, size_t s, logic sx, addr_mode_t m,
                                  logic add, logic [11:0] imm, logic [31:0] base);
        return '{kind: k, size: s, sign_ext: sx, mode: m, cond_pass: 1'b1,
                 add_offset: add, imm: imm, transfer_register: 4'h2,
                 second_transfer_register: 4'h3, base_register: 4'h5, base_val: base,
                 pc_val: 32'h0000_2000, store_data: 32'hC3D2_B1A0,
                 store_data2: 32'h1E2F_3A4B};
    endfunction

    // flag writes must never appear
    always @(negedge sys_clk) begin
        if (!rst && flags_we !== 1'b0) chk("flag write", 32'h0, {31'h0, flags_we});
    end

    // offer one instruction, then log every port pulse until it retires
    task automatic run(input instr_t i);
        int n;
        n_req = 0;
        n_tr = 0;
        n_base = 0;
        n_br = 0;
        flt = 1'b0;
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        instr <= i;
        for (n = 0; n < 50 && instr_ready !== 1'b1; n++) @(negedge sys_clk);
        if (n == 50) begin chk("ready in time", 32'h1, 32'h0); wrap_up(); end
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        for (n = 0; n < 50; n++) begin
            @(negedge sys_clk);
            if (mem_req.valid === 1'b1) begin
                req_addr[n_req % 4] = mem_req.addr;
                req_wdata[n_req % 4] = mem_req.wdata;
                req_wr[n_req % 4] = mem_req.write;
                req_size[n_req % 4] = mem_req.size;
                n_req++;
            end
            if (tr_wr.en === 1'b1) begin
                tr_data[n_tr % 4] = tr_wr.data;
                tr_idx[n_tr % 4] = tr_wr.idx;
                n_tr++;
            end
            if (base_wr.en === 1'b1) begin
                n_base++;
                base_data = base_wr.data;
                base_idx = base_wr.idx;
            end
            if (branch.en === 1'b1) begin n_br++; br_tgt = branch.target; end
            if (done === 1'b1) begin flt = fault; break; end
        end
        if (n == 50) begin chk("retire in time", 32'h1, 32'h0); wrap_up(); end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_adr();
        instr_t i;
        i = mk(OP_ADR, SZ_WORD, 1'b0, AM_OFFSET, 1'b1, 12'hFFF, 32'h0);
        i.transfer_register = 4'h1;
        run(i);
        // odd sum keeps the result usable as an interworking branch target
        chk("adr plus", 32'h0000_2FFF, tr_data[0]);
        chk("adr dest", 32'h1, {28'h0, tr_idx[0]});
        chk("adr access", 32'h0, 32'(n_req));
        i.add_offset = 1'b0;
        run(i);
        chk("adr minus", 32'h0000_1001, tr_data[0]);
    endtask

    task automatic t_sizes();
        size_t       sz[5] = '{SZ_BYTE, SZ_BYTE, SZ_HALF, SZ_HALF, SZ_WORD};
        logic        sx[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [31:0] raw;
        logic [31:0] exp[5];
        raw = pat(32'h0000_900F);
        exp = '{{24'h0, raw[7:0]}, {{24{raw[7]}}, raw[7:0]}, {16'h0, raw[15:0]},
                {{16{raw[15]}}, raw[15:0]}, raw};
        for (int k = 0; k < 5; k++) begin
            lat <= 4'(k + 1);
            run(mk(OP_LOAD, sz[k], sx[k], AM_OFFSET, 1'b1, 12'hFFF, 32'h0000_8010));
            chk("load addr", 32'h0000_900F, req_addr[0]);
            chk("load size", {30'h0, sz[k]}, {30'h0, req_size[0]});
            chk("load value", exp[k], tr_data[0]);
            chk("offset writeback", 32'h0, 32'(n_base));
        end
    endtask

    task automatic t_index();
        run(mk(OP_LOAD, SZ_WORD, 1'b0, AM_PRE, 1'b0, 12'h0FF, 32'h0000_4100));
        chk("pre addr", 32'h0000_4001, req_addr[0]);
        chk("pre base", 32'h0000_4001, base_data);
        chk("pre base reg", 32'h5, {28'h0, base_idx});
        run(mk(OP_STORE, SZ_HALF, 1'b0, AM_POST, 1'b1, 12'h0FF, 32'h0000_4100));
        chk("post addr", 32'h0000_4100, req_addr[0]);
        chk("post data", 32'h0000_B1A0, req_wdata[0]);
        chk("post write", 32'h1, {31'h0, req_wr[0]});
        chk("post base", 32'h0000_41FF, base_data);
        chk("store regs", 32'h0, 32'(n_tr));
        run(mk(OP_STORE, SZ_BYTE, 1'b0, AM_OFFSET, 1'b1, 12'h000, 32'h0000_4100));
        chk("bare addr", 32'h0000_4100, req_addr[0]);
        chk("byte data", 32'h0000_00A0, req_wdata[0]);
    endtask

    task automatic t_pair();
        lat <= 4'h3;
        run(mk(OP_LOAD, SZ_PAIR, 1'b0, AM_PRE, 1'b0, 12'h3FC, 32'h0000_1400));
        chk("pair count", 32'h2, 32'(n_req));
        chk("pair addr2", 32'h0000_1008, req_addr[1]);
        chk("pair first", pat(32'h0000_1004), tr_data[0]);
        chk("pair second", pat(32'h0000_1008), tr_data[1]);
        chk("pair reg1", 32'h2, {28'h0, tr_idx[0]});
        chk("pair reg2", 32'h3, {28'h0, tr_idx[1]});
        chk("pair base", 32'h0000_1004, base_data);
        run(mk(OP_STORE, SZ_PAIR, 1'b0, AM_POST, 1'b1, 12'h3FC, 32'h0000_1400));
        chk("pst addr", 32'h0000_1404, req_addr[1]);
        chk("pst data2", 32'h1E2F_3A4B, req_wdata[1]);
        chk("pst base", 32'h0000_17FC, base_data);
    endtask

    task automatic t_faults();
        size_t       sz[4] = '{SZ_WORD, SZ_BYTE, SZ_PAIR, SZ_PAIR};
        addr_mode_t  md[4] = '{AM_PRE, AM_OFFSET, AM_OFFSET, AM_POST};
        logic [11:0] im[4] = '{12'h100, 12'h100, 12'h006, 12'h400};
        logic        ad[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
        for (int k = 0; k < 4; k++) begin
            run(mk(OP_LOAD, sz[k], 1'b0, md[k], ad[k], im[k], 32'h0000_3000));
            chk("range fault", 32'h1, {31'h0, flt});
            chk("fault effect", 32'h0, 32'(n_req + n_tr + n_base));
        end
    endtask

    task automatic t_branch();
        instr_t i;
        i = mk(OP_LOAD, SZ_WORD, 1'b0, AM_OFFSET, 1'b1, 12'h000, 32'h0000_0200);
        // unconditional, so no conditional block ordering applies
        i.transfer_register = 4'hF;
        run(i);
        chk("branch count", 32'h1, 32'(n_br));
        chk("branch target", pat(32'h0000_0200) & 32'hFFFF_FFFE, br_tgt);
        chk("branch reg", 32'h0, 32'(n_tr));
    endtask

    task automatic t_cond();
        instr_t i;
        i = mk(OP_STORE, SZ_WORD, 1'b0, AM_PRE, 1'b1, 12'h010, 32'h0000_5000);
        i.cond_pass = 1'b0;
        run(i);
        chk("cond store", 32'h0, 32'(n_req + n_tr + n_base));
        i.kind = OP_ADR;
        run(i);
        chk("cond adr", 32'h0, 32'(n_req + n_tr + n_base));
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_adr();
        t_sizes();
        t_index();
        t_pair();
        t_faults();
        t_branch();
        t_cond();
        wrap_up();
    end
endmodule
`default_nettype wire
